/* verilog/lscrc_target.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Claimed register cycles get at least two long-wait syncs before ready.
// - Extra waits while the internal access has not returned its data.
// - Waits always use the long-wait code, never the short one.
// - Cycles follow the bus clock; waits stay within eight unless internally delayed.
// - Error sync is never driven.
// - Power-down asserted then removed without bus reset leaves logic working.
// - Mode 0 keeps the clock-run pin released whatever interrupts do.
// - Mode 1 enables the clock-run pin and interrupt driven restart.
// - Clock-run is open drain: pulled low or released only.
// - Clock-run high means clock stopped or stopping, low means running.
// - Mode 1, line high, interrupt change or new DMA request: pull clock-run low.
// - Hold clock-run low for two bus clock rising edges, then release.
// - Never pull clock-run while the clock source already holds it low.
// - Pull only after the line was seen high on two successive clocks.
// - Any edge on any routed interrupt counts as a change, in every mode.
// - Keep requesting until the change is framed or the DMA request served.
// - Claim only cycles inside our own windows, ignore all others silently.
// - Outputs float during bus reset or power-down.
// - Pulse a wake event whenever bus traffic starts.
module lscrc_target #(
	parameter int IRQ_W    = 16,
	parameter int DRQ_W    = 4,
	parameter int MIN_WAIT = lscrc_pkg::MIN_WAIT_SYNCS,
	parameter int MAX_WAIT = lscrc_pkg::MAX_WAIT_STATES
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    lclk,
	input  wire logic                    lframeN,
	input  wire logic [3:0]              ladIn,
	input  wire logic                    lresetN,
	input  wire logic                    lpcpdN,
	input  wire logic                    clkrunNIn,
	input  wire logic                    serialIrqEnableMode,
	input  wire logic [IRQ_W-1:0]        irqIn,
	input  wire logic [DRQ_W-1:0]        drqIn,
	input  wire logic                    sirqFrameDone,
	input  wire logic                    dmaServed,
	input  wire lscrc_pkg::lscrc_window_t ioWindow,
	input  wire lscrc_pkg::lscrc_window_t memWindow,
	input  wire logic                    ackValid,
	input  wire logic [7:0]              ackData,
	output lscrc_pkg::lscrc_pins_t       pins,
	output logic                         reqValid,
	output lscrc_pkg::lscrc_req_t        req,
	output logic                         busTrafficWake
);
	import lscrc_pkg::*;

	generate
		if (MIN_WAIT < 2 || MIN_WAIT > MAX_WAIT || MAX_WAIT > 14 || IRQ_W < 1 || DRQ_W < 1) begin : g_bad
			$error("lscrc_target: unsupported parameter values");
		end
	endgenerate

	localparam int SW = 9 + IRQ_W + DRQ_W;
	localparam logic [3:0] MIN_WAIT_L = 4'(MIN_WAIT);

	function automatic logic windowHit(input logic [31:0] a, input lscrc_window_t w);
		windowHit = w.valid && ((a & ~w.mask) == (w.base & ~w.mask));
	endfunction : windowHit

	// Every pin input passes two flops; only the second stage is read below
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	always_ff @(posedge clk) begin
		sync1_reg <= {lclk, lframeN, ladIn, lresetN, lpcpdN, clkrunNIn, irqIn, drqIn};
		sync2_reg <= sync1_reg;
	end

	logic             lclkS;
	logic             lframeS;
	logic [3:0]       ladS;
	logic             lresetS;
	logic             lpcpdS;
	logic             clkrunS;
	logic [IRQ_W-1:0] irqS;
	logic [DRQ_W-1:0] drqS;
	assign {lclkS, lframeS, ladS, lresetS, lpcpdS, clkrunS, irqS, drqS} = sync2_reg;

	logic             lclkPrev_reg;
	logic [IRQ_W-1:0] irqPrev_reg;
	logic [DRQ_W-1:0] drqPrev_reg;
	always_ff @(posedge clk) begin
		lclkPrev_reg <= lclkS;
		irqPrev_reg  <= irqS;
		drqPrev_reg  <= drqS;
	end

	logic lclkRise;
	logic busAbort;
	assign lclkRise = lclkS & ~lclkPrev_reg;
	assign busAbort = ~lresetS | ~lpcpdS;

	// Bus cycle engine
	lscrc_bus_state_t busState_reg, busNext;
	logic [3:0]  nib_reg, nibNext;
	logic [3:0]  wait_reg, waitNext;
	logic        cWr_reg, cWrNext;
	logic        cMem_reg, cMemNext;
	logic [31:0] addr_reg, addrNext;
	logic [7:0]  wdata_reg, wdataNext;
	logic [7:0]  rdata_reg, rdataNext;
	logic        ready_reg, readyNext;
	logic [3:0]  ladOut_reg, ladOutNext;
	logic        ladOe_reg, ladOeNext;
	logic        reqValid_reg, reqValidNext;
	lscrc_req_t  req_reg, reqNext;
	logic        wake_reg, wakeNext;

	always_comb begin
		busNext      = busState_reg;
		nibNext      = nib_reg;
		waitNext     = wait_reg;
		cWrNext      = cWr_reg;
		cMemNext     = cMem_reg;
		addrNext     = addr_reg;
		wdataNext    = wdata_reg;
		rdataNext    = ackValid ? ackData : rdata_reg;
		readyNext    = ready_reg | ackValid;
		ladOutNext   = ladOut_reg;
		ladOeNext    = ladOe_reg;
		reqValidNext = 1'b0;
		reqNext      = req_reg;
		wakeNext     = 1'b0;
		if (busAbort) begin
			busNext   = B_IDLE;
			ladOeNext = 1'b0;
			readyNext = 1'b0;
		end else if (lclkRise) begin
			if (!lframeS) begin
				// Start or host abort; either way our drivers let go
				ladOeNext = 1'b0;
				readyNext = 1'b0;
				busNext   = B_IDLE;
				if (ladS == NIB_START) begin
					busNext  = B_CTYPE;
					wakeNext = 1'b1;
				end
			end else begin
				case (busState_reg)
					B_IDLE: begin
						busNext = B_IDLE;
					end
					B_CTYPE: begin
						cWrNext  = ladS[DIR_BIT];
						cMemNext = (ladS[TYPE_MSB:TYPE_LSB] == TYPE_MEM);
						addrNext = '0;
						nibNext  = '0;
						if (ladS[TYPE_MSB:TYPE_LSB] == TYPE_IO || ladS[TYPE_MSB:TYPE_LSB] == TYPE_MEM) begin
							busNext = B_ADDR;
						end else begin
							busNext = B_IDLE;
						end
					end
					B_ADDR: begin
						addrNext = {addr_reg[27:0], ladS};
						nibNext  = nib_reg + 4'h1;
						if (nibNext == (cMem_reg ? MEM_ADDR_NIBS : {1'b0, IO_ADDR_NIBS})) begin
							nibNext = '0;
							busNext = cWr_reg ? B_WDATA : B_TAR1;
						end
					end
					B_WDATA: begin
						nibNext = nib_reg + 4'h1;
						if (nib_reg == 4'h0) begin
							wdataNext[3:0] = ladS;
						end else begin
							wdataNext[7:4] = ladS;
							busNext        = B_TAR1;
						end
					end
					B_TAR1: begin
						if (windowHit(addr_reg, cMem_reg ? memWindow : ioWindow)) begin
							reqValidNext = 1'b1;
							reqNext      = '{write: cWr_reg, mem: cMem_reg, addr: addr_reg, wdata: wdata_reg};
							readyNext    = 1'b0;
							busNext      = B_TAR2;
						end else begin
							busNext = B_IDLE;
						end
					end
					B_TAR2: begin
						ladOutNext = SYNC_LONG;
						ladOeNext  = 1'b1;
						waitNext   = 4'h1;
						busNext    = B_SYNC;
					end
					B_SYNC: begin
						if (wait_reg >= MIN_WAIT_L && ready_reg) begin
							ladOutNext = SYNC_READY;
							busNext    = B_RDY;
						end else begin
							ladOutNext = SYNC_LONG;
							if (wait_reg != WAIT_SAT) begin
								waitNext = wait_reg + 4'h1;
							end
						end
					end
					B_RDY: begin
						if (cWr_reg) begin
							ladOutNext = NIB_TAR;
							busNext    = B_TARO;
						end else begin
							ladOutNext = rdata_reg[3:0];
							busNext    = B_RDL;
						end
					end
					B_RDL: begin
						ladOutNext = rdata_reg[7:4];
						busNext    = B_RDH;
					end
					B_RDH: begin
						ladOutNext = NIB_TAR;
						busNext    = B_TARO;
					end
					B_TARO: begin
						ladOeNext = 1'b0;
						busNext   = B_IDLE;
					end
					default: begin
						ladOeNext = 1'b0;
						busNext   = B_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busState_reg <= B_IDLE;
			nib_reg      <= '0;
			wait_reg     <= '0;
			cWr_reg      <= 1'b0;
			cMem_reg     <= 1'b0;
			addr_reg     <= '0;
			wdata_reg    <= '0;
			rdata_reg    <= '0;
			ready_reg    <= 1'b0;
			ladOut_reg   <= NIB_TAR;
			ladOe_reg    <= 1'b0;
			reqValid_reg <= 1'b0;
			req_reg      <= '0;
			wake_reg     <= 1'b0;
		end else begin
			busState_reg <= busNext;
			nib_reg      <= nibNext;
			wait_reg     <= waitNext;
			cWr_reg      <= cWrNext;
			cMem_reg     <= cMemNext;
			addr_reg     <= addrNext;
			wdata_reg    <= wdataNext;
			rdata_reg    <= rdataNext;
			ready_reg    <= readyNext;
			ladOut_reg   <= ladOutNext;
			ladOe_reg    <= ladOeNext;
			reqValid_reg <= reqValidNext;
			req_reg      <= reqNext;
			wake_reg     <= wakeNext;
		end
	end

	// Clock restart request. Edges are seen through the synchroniser, so the
	// pull starts a few system clocks after the change rather than instantly.
	lscrc_cr_state_t crState_reg, crNext;
	logic       irqPend_reg, irqPendNext;
	logic       drqPend_reg, drqPendNext;
	logic [1:0] crHigh_reg, crHighNext;
	logic [1:0] crEdges_reg, crEdgesNext;
	logic       crOe_reg, crOeNext;

	always_comb begin
		crNext      = crState_reg;
		crHighNext  = crHigh_reg;
		crEdgesNext = crEdges_reg;
		crOeNext    = crOe_reg;
		// Set wins over clear so a change in the frame-done cycle is kept
		irqPendNext = (|(irqS ^ irqPrev_reg)) | (irqPend_reg & ~sirqFrameDone);
		drqPendNext = (|(drqS & ~drqPrev_reg)) | (drqPend_reg & ~dmaServed);
		if (lclkRise) begin
			if (clkrunS && crHigh_reg != CR_HIGH_SAMPLES) begin
				crHighNext = crHigh_reg + 2'h1;
			end else if (!clkrunS) begin
				crHighNext = '0;
			end
		end
		if (busAbort || !serialIrqEnableMode) begin
			crNext   = CR_IDLE;
			crOeNext = 1'b0;
		end else begin
			case (crState_reg)
				CR_IDLE: begin
					if ((irqPend_reg || drqPend_reg) && clkrunS && crHigh_reg == CR_HIGH_SAMPLES) begin
						crNext      = CR_DRIVE;
						crOeNext    = 1'b1;
						crEdgesNext = '0;
						crHighNext  = '0;
					end
				end
				CR_DRIVE: begin
					if (lclkRise) begin
						crEdgesNext = crEdges_reg + 2'h1;
						if (crEdgesNext == CR_HOLD_EDGES) begin
							crNext   = CR_IDLE;
							crOeNext = 1'b0;
						end
					end
				end
				default: begin
					crNext   = CR_IDLE;
					crOeNext = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			crState_reg <= CR_IDLE;
			irqPend_reg <= 1'b0;
			drqPend_reg <= 1'b0;
			crHigh_reg  <= '0;
			crEdges_reg <= '0;
			crOe_reg    <= 1'b0;
		end else begin
			crState_reg <= crNext;
			irqPend_reg <= irqPendNext;
			drqPend_reg <= drqPendNext;
			crHigh_reg  <= crHighNext;
			crEdges_reg <= crEdgesNext;
			crOe_reg    <= crOeNext;
		end
	end

	assign pins           = '{ladOut: ladOut_reg, ladOe: ladOe_reg, clkrunOut: 1'b0, clkrunOe: crOe_reg};
	assign reqValid       = reqValid_reg;
	assign req            = req_reg;
	assign busTrafficWake = wake_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_readyEmit;
		busState_reg == B_SYNC && busNext == B_RDY;
	endsequence
	sequence s_startSeen;
		lclkRise && !busAbort && !lframeS && ladS == NIB_START;
	endsequence

	a_ready_min_wait: assert property (s_readyEmit |-> wait_reg >= MIN_WAIT_L)
		else $error("ready sync sent too early");
	a_wait_no_data: assert property (busState_reg == B_SYNC && lclkRise && !ready_reg && !busAbort && lframeS
		|=> busState_reg == B_SYNC && ladOut_reg == SYNC_LONG)
		else $error("ready sent before data");
	a_sync_long_only: assert property (busState_reg == B_SYNC && ladOe_reg |-> ladOut_reg == SYNC_LONG)
		else $error("wait sync not long code");
	a_no_error_sync: assert property (ladOe_reg && busState_reg inside {B_SYNC, B_RDY}
		|-> ladOut_reg != SYNC_ERR)
		else $error("error sync driven");
	a_mode_off_quiet: assert property (!serialIrqEnableMode && !$past(serialIrqEnableMode) |-> !crOe_reg)
		else $error("clock-run driven with mode off");
	a_pull_needs_high: assert property ($rose(crOe_reg) |-> $past(clkrunS) && $past(crHigh_reg) == CR_HIGH_SAMPLES)
		else $error("clock-run pulled without two high samples");
	a_hold_two_edges: assert property ($fell(crOe_reg) && $past(serialIrqEnableMode) && !$past(busAbort)
		|-> $past(crEdges_reg) == CR_HOLD_EDGES - 2'h1 && $past(lclkRise))
		else $error("clock-run released early");
	a_pd_abort: assert property (busAbort |=> busState_reg == B_IDLE && !ladOe_reg && !crOe_reg)
		else $error("outputs not floated on power-down");
	a_wake_on_start: assert property (s_startSeen |=> busTrafficWake ##1 !busTrafficWake)
		else $error("wake not pulsed on bus start");

endmodule : lscrc_target

/* verilog/lscrc_pkg.sv */
package lscrc_pkg;

	// Nibble codes on the multiplexed address/data lines
	localparam logic [3:0] NIB_START  = 4'h0;
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] SYNC_LONG  = 4'h6;
	localparam logic [3:0] SYNC_ERR   = 4'hA;
	localparam logic [3:0] NIB_TAR    = 4'hF;

	// Cycle type nibble layout
	localparam int         TYPE_MSB = 3;
	localparam int         TYPE_LSB = 2;
	localparam int         DIR_BIT  = 1;
	localparam logic [1:0] TYPE_IO  = 2'h0;
	localparam logic [1:0] TYPE_MEM = 2'h1;

	localparam logic [2:0] IO_ADDR_NIBS  = 3'h4;
	localparam logic [3:0] MEM_ADDR_NIBS = 4'h8;

	localparam int         MIN_WAIT_SYNCS  = 2;
	localparam int         MAX_WAIT_STATES = 8;
	localparam logic [3:0] WAIT_SAT        = 4'hF;
	localparam logic [1:0] CR_HOLD_EDGES   = 2'h2;
	localparam logic [1:0] CR_HIGH_SAMPLES = 2'h2;

	typedef enum logic [3:0] {
		B_IDLE  = 4'b0000,
		B_CTYPE = 4'b0001,
		B_ADDR  = 4'b0010,
		B_WDATA = 4'b0011,
		B_TAR1  = 4'b0100,
		B_TAR2  = 4'b0101,
		B_SYNC  = 4'b0110,
		B_RDY   = 4'b0111,
		B_RDL   = 4'b1000,
		B_RDH   = 4'b1001,
		B_TARO  = 4'b1010
	} lscrc_bus_state_t;

	typedef enum logic [1:0] {
		CR_IDLE  = 2'b00,
		CR_DRIVE = 2'b01
	} lscrc_cr_state_t;

	typedef struct packed {
		logic        write;
		logic        mem;
		logic [31:0] addr;
		logic [7:0]  wdata;
	} lscrc_req_t;

	typedef struct packed {
		logic [3:0] ladOut;
		logic       ladOe;
		logic       clkrunOut;
		logic       clkrunOe;
	} lscrc_pins_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] mask;
		logic        valid;
	} lscrc_window_t;

endpackage : lscrc_pkg

/* tb/lscrc_host_model.sv */
`timescale 1ns/10ps
module lscrc_host_model (
	input  wire logic       clk,
	input  wire logic       dutPull,
	input  wire logic [3:0] dutLad,
	input  wire logic       dutLadOe,
	output logic            lclk,
	output logic            lframeN,
	output logic [3:0]      ladWire,
	output logic            clkrunN
);
	logic       run;
	logic       genPull;
	logic [2:0] ph;
	logic [3:0] ladDrv;
	event       lrise;
	event       lfall;

	// With the target released the bus carries the host's ladDrv value
	assign ladWire = dutLadOe ? dutLad : ladDrv;
	assign clkrunN = ~(dutPull | genPull);

	initial begin
		run = 1'b1;
		genPull = 1'b1;
		ph = 3'h0;
		lclk = 1'b0;
		lframeN = 1'b1;
		ladDrv = 4'hF;
	end

	always @(posedge clk) begin
		// A pull by the target keeps or restarts the clock; we then hold the line low
		if (!clkrunN && !genPull) begin
			run <= 1'b1;
			genPull <= 1'b1;
		end
		if (run) begin
			ph <= ph + 3'h1;
			if (ph == 3'h3) begin
				lclk <= 1'b1;
				->lrise;
			end
			if (ph == 3'h7) begin
				lclk <= 1'b0;
				->lfall;
			end
		end
	end

	// Host changes the bus at the falling edge, samples at the rising one
	task automatic nib(input logic [3:0] v, input logic f, output logic [3:0] s, output logic o);
		@(lfall);
		ladDrv <= v;
		lframeN <= f;
		@(lrise);
		s = ladWire;
		o = dutLadOe;
	endtask : nib

	task automatic stop_clk();
		@(lfall);
		genPull <= 1'b0;
		repeat (4) @(lrise);
		@(lfall);
		// Stop only if nobody asked to keep the clock meanwhile
		if (!genPull) run <= 1'b0;
	endtask : stop_clk

	task automatic start_clk();
		@(posedge clk);
		genPull <= 1'b1;
		run <= 1'b1;
	endtask : start_clk

endmodule : lscrc_host_model

/* tb/lscrc_target_tb_top.sv */
`timescale 1ns/10ps
module lscrc_target_tb_top;
	import lscrc_pkg::*;
	localparam int PD_LEAD_CLKS = 1200; // 30 us of 25 ns clocks
	logic          clk, srst, lpcpdN, lresetN, mode, sirqFrameDone, dmaServed, ackValid;
	logic          lclk, lframeN, clkrunN, reqValid, busTrafficWake;
	logic [3:0]    ladWire;
	logic [15:0]   irq;
	logic [3:0]    drq;
	logic [7:0]    ackData, ackCnt, ackDelay;
	lscrc_window_t ioWindow, memWindow;
	lscrc_pins_t   pins;
	lscrc_req_t    req, reqSeen;
	int            failures, n_checks, reqCnt, wakeCnt;

	lscrc_host_model u_lscrc_host_model (
		.clk      (clk),
		.dutPull  (pins.clkrunOe),
		.dutLad   (pins.ladOut),
		.dutLadOe (pins.ladOe),
		.lclk     (lclk),
		.lframeN  (lframeN),
		.ladWire  (ladWire),
		.clkrunN  (clkrunN)
	);

	lscrc_target u_lscrc_target (
		.clk                 (clk),
		.srst                (srst),
		.lclk                (lclk),
		.lframeN             (lframeN),
		.ladIn               (ladWire),
		.lresetN             (lresetN),
		.lpcpdN              (lpcpdN),
		.clkrunNIn           (clkrunN),
		.serialIrqEnableMode (mode),
		.irqIn               (irq),
		.drqIn               (drq),
		.sirqFrameDone       (sirqFrameDone),
		.dmaServed           (dmaServed),
		.ioWindow            (ioWindow),
		.memWindow           (memWindow),
		.ackValid            (ackValid),
		.ackData             (ackData),
		.pins                (pins),
		.reqValid            (reqValid),
		.req                 (req),
		.busTrafficWake      (busTrafficWake)
	);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (reqValid) reqCnt <= reqCnt + 1;
		if (reqValid) reqSeen <= req;
		if (busTrafficWake) wakeCnt <= wakeCnt + 1;
	end

	// Internal side answers after ackDelay clocks; power-down drops it
	always @(posedge clk) begin
		ackValid <= 1'b0;
		if (!lpcpdN || !lresetN) ackCnt <= 8'h00;
		else if (reqValid) ackCnt <= ackDelay;
		else if (ackCnt != 8'h00) begin
			ackCnt <= ackCnt - 8'h01;
			ackValid <= (ackCnt == 8'h01);
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic bus(input logic mem, input logic wr, input logic [31:0] a, input logic [7:0] wd,
			output logic [7:0] rd, output int waits, output logic resp, output logic bad);
		logic [3:0] s;
		logic       o;
		waits = 0;
		resp = 1'b0;
		bad = 1'b0;
		rd = 8'h00;
		u_lscrc_host_model.nib(4'h0, 1'b0, s, o);
		u_lscrc_host_model.nib({1'b0, mem, wr, 1'b0}, 1'b1, s, o);
		for (int i = (mem ? 7 : 3); i >= 0; i--) u_lscrc_host_model.nib(a[i*4+:4], 1'b1, s, o);
		if (wr) u_lscrc_host_model.nib(wd[3:0], 1'b1, s, o);
		if (wr) u_lscrc_host_model.nib(wd[7:4], 1'b1, s, o);
		u_lscrc_host_model.nib(4'hF, 1'b1, s, o);
		u_lscrc_host_model.nib(4'hF, 1'b1, s, o);
		for (int i = 0; i < 20; i++) begin
			u_lscrc_host_model.nib(4'hF, 1'b1, s, o);
			if (o !== 1'b1) break;
			resp = 1'b1;
			if (s === SYNC_READY) break;
			if (s === SYNC_LONG) waits++;
			else bad = 1'b1;
		end
		if (resp && !wr) u_lscrc_host_model.nib(4'hF, 1'b1, rd[3:0], o);
		if (resp && !wr) u_lscrc_host_model.nib(4'hF, 1'b1, rd[7:4], o);
		if (resp) u_lscrc_host_model.nib(4'hF, 1'b1, s, o);
	endtask : bus

	task automatic t_read(input logic [7:0] d);
		logic [7:0] rd;
		int         w, r0, k0;
		logic       resp, bad;
		r0 = reqCnt;
		k0 = wakeCnt;
		ackDelay = 8'h01;
		@(posedge clk) ackData <= d;
		bus(1'b0, 1'b0, 32'h0000_0064, 8'h00, rd, w, resp, bad);
		chk(resp, 1, "io read not claimed");
		chk(w >= MIN_WAIT_SYNCS, 1, "too few waits");
		chk(w <= MAX_WAIT_STATES, 1, "too many waits");
		chk(bad, 0, "bad sync code");
		chk(rd, d, "read data");
		chk(reqCnt - r0, 1, "request count");
		chk({reqSeen.mem, reqSeen.write, reqSeen.addr}, 34'h0_0000_0064, "request fields");
		chk(wakeCnt - k0, 1, "wake pulse");
		// Release follows the last sampled edge by the sync delay
		repeat (8) @(posedge clk);
		chk(pins.ladOe, 0, "bus not released");
	endtask : t_read

	task automatic t_mem_write();
		logic [7:0] rd;
		int         w;
		logic       resp, bad;
		ackDelay = 8'h28;
		bus(1'b1, 1'b1, 32'h000F_3010, 8'h5A, rd, w, resp, bad);
		chk(resp, 1, "mem write not claimed");
		chk(w > MIN_WAIT_SYNCS, 1, "slow access got no extra waits");
		chk(w <= MAX_WAIT_STATES, 1, "too many waits");
		chk(bad, 0, "bad sync code");
		chk({reqSeen.mem, reqSeen.write, reqSeen.addr, reqSeen.wdata}, 42'h3_000F_3010_5A, "write fields");
	endtask : t_mem_write

	task automatic t_unclaimed();
		logic [7:0] rd;
		int         w, r0, k0;
		logic       resp, bad;
		r0 = reqCnt;
		k0 = wakeCnt;
		bus(1'b0, 1'b0, 32'h0000_0080, 8'h00, rd, w, resp, bad);
		chk(resp, 0, "foreign cycle answered");
		chk(reqCnt - r0, 0, "foreign cycle forwarded");
		chk(wakeCnt - k0, 1, "no wake on traffic");
	endtask : t_unclaimed

	task automatic t_io_write_mem_read();
		logic [7:0] rd;
		int         w;
		logic       resp, bad;
		ackDelay = 8'h01;
		bus(1'b0, 1'b1, 32'h0000_0060, 8'h3C, rd, w, resp, bad);
		chk(resp, 1, "io write not claimed");
		chk(bad, 0, "bad sync code");
		chk({reqSeen.mem, reqSeen.write, reqSeen.addr, reqSeen.wdata}, 42'h1_0000_0060_3C, "io write fields");
		@(posedge clk) ackData <= 8'h96;
		bus(1'b1, 1'b0, 32'h000F_30FF, 8'h00, rd, w, resp, bad);
		chk(resp, 1, "mem read not claimed");
		chk(w, MIN_WAIT_SYNCS, "fast read waits");
		chk(bad, 0, "bad sync code");
		chk(rd, 8'h96, "mem read data");
		chk({reqSeen.mem, reqSeen.write, reqSeen.addr}, 34'h2_000F_30FF, "mem read fields");
	endtask : t_io_write_mem_read

	task automatic t_power_down(input logic viaReset);
		logic [7:0] rd;
		int         w;
		logic       resp, bad;
		ackDelay = 8'hC8;
		fork
			bus(1'b0, 1'b0, 32'h0000_0060, 8'h00, rd, w, resp, bad);
			begin
				for (int i = 0; i < 400 && pins.ladOe !== 1'b1; i++) @(posedge clk);
				repeat (8) @(posedge clk);
				if (viaReset) lresetN <= 1'b0;
				else lpcpdN <= 1'b0;
				repeat (8) @(posedge clk);
				chk(pins.ladOe, 0, "bus driven in power-down");
				chk(pins.clkrunOe, 0, "clock-run driven in power-down");
			end
		join
		// Clock may stop only once power-down has stood its lead time
		repeat (PD_LEAD_CLKS) @(posedge clk);
		u_lscrc_host_model.stop_clk();
		@(posedge clk);
		lpcpdN <= 1'b1;
		lresetN <= 1'b1;
		u_lscrc_host_model.start_clk();
		repeat (8) @(posedge clk);
		t_read(8'hA5);
	endtask : t_power_down

	task automatic pull_seq(input logic edges);
		for (int i = 0; i < 40 && pins.clkrunOe !== 1'b1; i++) @(posedge clk);
		chk(pins.clkrunOe, 1, "no restart request");
		chk(pins.clkrunOut, 0, "clock-run driven high");
		if (edges) begin
			@(u_lscrc_host_model.lrise);
			repeat (6) @(posedge clk);
			chk(pins.clkrunOe, 1, "released early");
			@(u_lscrc_host_model.lrise);
			repeat (6) @(posedge clk);
			chk(pins.clkrunOe, 0, "not released");
		end
	endtask : pull_seq

	task automatic t_clkrun();
		u_lscrc_host_model.stop_clk();
		@(posedge clk) mode <= 1'b0;
		@(posedge clk) irq <= irq ^ 16'h0020;
		repeat (40) @(posedge clk);
		chk({pins.clkrunOe, u_lscrc_host_model.run}, 0, "pull in mode 0");
		@(posedge clk) sirqFrameDone <= 1'b1;
		@(posedge clk) sirqFrameDone <= 1'b0;
		mode <= 1'b1;
		repeat (20) @(posedge clk);
		irq <= irq ^ 16'h8000;
		pull_seq(1'b1);
		// Pending change never framed: request repeats while the clock is stopping
		fork
			u_lscrc_host_model.stop_clk();
			pull_seq(1'b0);
		join
		repeat (40) @(posedge clk);
		@(posedge clk) sirqFrameDone <= 1'b1;
		@(posedge clk) sirqFrameDone <= 1'b0;
		irq <= irq ^ 16'h0001;
		repeat (40) @(posedge clk);
		chk(pins.clkrunOe, 0, "pulled while held low");
		@(posedge clk) sirqFrameDone <= 1'b1;
		@(posedge clk) sirqFrameDone <= 1'b0;
		u_lscrc_host_model.stop_clk();
		repeat (40) @(posedge clk);
		chk({pins.clkrunOe, u_lscrc_host_model.run}, 0, "pull after frame done");
		@(posedge clk) drq <= 4'h2;
		pull_seq(1'b1);
		@(posedge clk) dmaServed <= 1'b1;
		@(posedge clk) dmaServed <= 1'b0;
	endtask : t_clkrun

	initial begin
		clk = 1'b0;
		srst = 1'b1;
		lpcpdN = 1'b1;
		lresetN = 1'b1;
		mode = 1'b1;
		irq = '0;
		drq = '0;
		sirqFrameDone = 1'b0;
		dmaServed = 1'b0;
		ackData = 8'h00;
		ackDelay = 8'h01;
		ioWindow = '{32'h0000_0060, 32'h0000_0004, 1'b1};
		memWindow = '{32'h000F_3000, 32'h0000_00FF, 1'b1};
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({pins.ladOe, pins.clkrunOe, reqCnt}, 0, "outputs after reset");
		t_read(8'hC3);
		t_mem_write();
		t_unclaimed();
		t_io_write_mem_read();
		t_power_down(1'b0);
		t_power_down(1'b1);
		t_clkrun();
		wrap_up();
	end

	// Whole run needs well under 20000 clocks
	initial begin
		#1000000;
		failures++;
		wrap_up();
	end

endmodule : lscrc_target_tb_top
